// ### bench/sowr_system_options_properties.sv
// checker for the system option registers, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module sowr_system_options_properties
  import sowr_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        por_reset,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        stop_request,
  input wire logic        analog_comparator_output,
  input wire logic        stop_mode_enter,
  input wire logic        illegal_opcode_reset,
  input wire logic        capture_ch0_from_comparator,
  input wire sowr_opts_s  opts
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rst_exit;
    $rose(aresetn);
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  stop_enter_a: assert property (
    stop_mode_enter == (stop_request && opts.stop_mode_allow)) else $error("stop entry mismatch");
  illegal_op_a: assert property (
    illegal_opcode_reset == (stop_request && !opts.stop_mode_allow))
    else $error("illegal opcode reset mismatch");
  pullup_follow_a: assert property (opts.reset_pin_pullup_en == opts.reset_pin_enable)
    else $error("pull-up does not follow reset pin enable");
  cmp_route_a: assert property (capture_ch0_from_comparator ==
    (analog_comparator_output && opts.comparator_to_capture_route)) else $error("capture route wrong");
  debug_reset_a: assert property (rst_exit |-> opts.debug_pin_enable)
    else $error("debug pin not restored by reset");
  por_clear_a: assert property (rst_exit and $past(por_reset) |-> !opts.reset_pin_enable)
    else $error("reset pin enable not cleared by power-on reset");
  rdata_reserved_a: assert property (s_axi_rvalid |-> s_axi_rdata[3:2] == 2'b00)
    else $error("reserved bits read nonzero");
  read_resp_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  opts_change_a: assert property ($changed(opts.watchdog_enable) |-> $rose(s_axi_bvalid))
    else $error("option changed without a write");
endmodule
bind sowr_system_options sowr_system_options_properties i_props (.aclk, .aresetn, .por_reset,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .stop_request, .analog_comparator_output, .stop_mode_enter, .illegal_opcode_reset,
  .capture_ch0_from_comparator, .opts);
`default_nettype wire

// ### bench/tb.sv
// directed testbench for the system option registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sowr_pkg::*;
  logic aclk, aresetn, por_reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, stop_request, cmp_in, stop_enter, ill_rst;
  logic cap_cmp, cap_sel;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  sowr_opts_s opts;
  int fails, samples_checked, cyc;
  sowr_system_options i_sowr_system_options (.aclk, .aresetn, .por_reset,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stop_request, .analog_comparator_output(cmp_in), .stop_mode_enter(stop_enter),
    .illegal_opcode_reset(ill_rst), .capture_ch0_from_comparator(cap_cmp),
    .capture_ch0_compare_sel(cap_sel), .opts);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic final_report();
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rst(input logic por);
    aresetn <= 1'b0;
    por_reset <= por;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk("rdata", {24'h00_0000, e}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
  endtask
  task automatic chk_opts(input logic [8:0] e);
    chk("opts", {23'h0, e}, {23'h0, opts});
  endtask
  initial begin
    {aresetn, por_reset, awvalid, wvalid, bready, arvalid, rready, stop_request} = '0;
    cmp_in = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    cyc = 0;
    rst(1'b1);
    rd(SOWR_PRIMARY_OFFS, 8'hD2, AXI_RESP_OKAY);
    rd(SOWR_SECONDARY_OFFS, 8'h00, AXI_RESP_OKAY);
    chk_opts(9'h1A0);
    @(posedge aclk) stop_request <= 1'b1;
    @(posedge aclk);
    chk("illegal", 32'h0000_0001, {31'h0, ill_rst});
    wr(SOWR_PRIMARY_OFFS, 8'h3D, AXI_RESP_OKAY);
    rd(SOWR_PRIMARY_OFFS, 8'h31, AXI_RESP_OKAY);
    wr(SOWR_PRIMARY_OFFS, 8'hC2, AXI_RESP_OKAY);
    rd(SOWR_PRIMARY_OFFS, 8'h31, AXI_RESP_OKAY);
    chk("stop", 32'h0000_0001, {31'h0, stop_enter});
    wr(SOWR_SECONDARY_OFFS, 8'h83, AXI_RESP_OKAY);
    rd(SOWR_SECONDARY_OFFS, 8'h83, AXI_RESP_OKAY);
    chk_opts(9'h05F);
    chk("capture", 32'h0000_0003, {30'h0, cap_cmp, cap_sel});
    @(posedge aclk) cmp_in <= 1'b0;
    @(posedge aclk);
    chk("capture", 32'h0000_0001, {30'h0, cap_cmp, cap_sel});
    wr(SOWR_SECONDARY_OFFS, 8'h00, AXI_RESP_OKAY);
    rd(SOWR_SECONDARY_OFFS, 8'h80, AXI_RESP_OKAY);
    wstrb <= 4'hE;
    wr(SOWR_SECONDARY_OFFS, 8'h03, AXI_RESP_OKAY);
    rd(SOWR_SECONDARY_OFFS, 8'h80, AXI_RESP_OKAY);
    wstrb <= 4'hF;
    chk_opts(9'h05C);
    wr(4'h8, 8'h55, AXI_RESP_SLVERR);
    rd(4'h8, 8'h00, AXI_RESP_SLVERR);
    rst(1'b0);
    rd(SOWR_PRIMARY_OFFS, 8'hD3, AXI_RESP_OKAY);
    rd(SOWR_SECONDARY_OFFS, 8'h00, AXI_RESP_OKAY);
    wr(SOWR_PRIMARY_OFFS, 8'h01, AXI_RESP_OKAY);
    rd(SOWR_PRIMARY_OFFS, 8'h01, AXI_RESP_OKAY);
    rst(1'b1);
    rd(SOWR_PRIMARY_OFFS, 8'hD2, AXI_RESP_OKAY);
    final_report();
  end
endmodule
`default_nettype wire

// ### include/sowr_pkg.sv
// shared constants and carriers for the system option registers
`default_nettype none
package sowr_pkg;

  localparam int unsigned AXI_AW = 4;

  // register byte addresses
  localparam logic [AXI_AW-1:0] SOWR_PRIMARY_OFFS   = 4'h0;
  localparam logic [AXI_AW-1:0] SOWR_SECONDARY_OFFS = 4'h4;

  // primary register field positions
  localparam int unsigned PRI_WDOG_EN_BIT   = 7;
  localparam int unsigned PRI_WDOG_LONG_BIT = 6;
  localparam int unsigned PRI_STOP_BIT      = 5;
  localparam int unsigned PRI_SPARE_BIT     = 4;
  localparam int unsigned PRI_DBG_PIN_BIT   = 1;
  localparam int unsigned PRI_RST_PIN_BIT   = 0;

  // secondary register field positions
  localparam int unsigned SEC_WDOG_CLK_BIT  = 7;
  localparam int unsigned SEC_I2C_LOC_BIT   = 1;
  localparam int unsigned SEC_CMP_ROUTE_BIT = 0;

  // writable masks and reset values
  localparam logic [7:0] PRI_WR_MASK   = 8'hF3;
  localparam logic [7:0] SEC_WR_MASK   = 8'h83;
  localparam logic [7:0] PRI_RST_VALUE = 8'hD2;
  localparam logic [7:0] SEC_RST_VALUE = 8'h00;

  localparam logic [1:0] AXI_RESP_OKAY   = 2'b00;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'b10;

  // decoded option outputs
  typedef struct packed {
    logic watchdog_enable;
    logic watchdog_long_timeout;
    logic stop_mode_allow;
    logic debug_pin_enable;
    logic reset_pin_enable;
    logic reset_pin_pullup_en;
    logic watchdog_clock_select;
    logic i2c_pin_location_select;
    logic comparator_to_capture_route;
  } sowr_opts_s;

  // one register write request
  typedef struct packed {
    logic       wr;
    logic [7:0] data;
    logic [3:0] strb;
  } sowr_wreq_s;

endpackage
`default_nettype wire

// ### logic/sowr_axil_slave.sv
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module sowr_axil_slave
  import sowr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output sowr_wreq_s             pri_wreq,
  output sowr_wreq_s             sec_wreq,
  input  wire logic [7:0]        pri_rdata,
  input  wire logic [7:0]        sec_rdata
);

  logic [AXI_AW-1:0] awaddr_q;
  logic              aw_have_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              w_have_q;
  logic              do_write;
  logic              hit_pri;
  logic              hit_sec;

  function automatic logic addr_is(input logic [AXI_AW-1:0] a, input logic [AXI_AW-1:0] offs);
    addr_is = (a == offs);
  endfunction

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;
  assign hit_pri       = addr_is(awaddr_q, SOWR_PRIMARY_OFFS);
  assign hit_sec       = addr_is(awaddr_q, SOWR_SECONDARY_OFFS);

  assign pri_wreq = '{wr: do_write && hit_pri && wstrb_q[0], data: wdata_q[7:0], strb: wstrb_q};
  assign sec_wreq = '{wr: do_write && hit_sec && wstrb_q[0], data: wdata_q[7:0], strb: wstrb_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (hit_pri || hit_sec) ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // upper 24 bits read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (addr_is(s_axi_araddr, SOWR_PRIMARY_OFFS)) begin
        s_axi_rdata <= {24'h00_0000, pri_rdata};
        s_axi_rresp <= AXI_RESP_OKAY;
      end else if (addr_is(s_axi_araddr, SOWR_SECONDARY_OFFS)) begin
        s_axi_rdata <= {24'h00_0000, sec_rdata};
        s_axi_rresp <= AXI_RESP_OKAY;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= AXI_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### logic/sowr_once_field.sv
// write-once field group: first write after reset is kept, later ones dropped
`timescale 1ns/1ps
`default_nettype none
module sowr_once_field
  import sowr_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         por_reset,
  input  wire logic [W-1:0] rst_value,
  input  wire logic [W-1:0] keep_mask,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] value_q,
  output logic              locked_q
);

  logic [W-1:0] value_d;

  // bits in keep_mask hold across a non-power reset
  always_comb begin
    value_d = value_q;
    if (!aresetn) begin
      value_d = por_reset ? rst_value : ((value_q & keep_mask) | (rst_value & ~keep_mask));
    end else if (wr_en && !locked_q) begin
      value_d = wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    value_q <= value_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_q <= 1'b0;
    end else if (wr_en) begin
      locked_q <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### logic/sowr_system_options.sv
// system option registers: write-once primary, mixed secondary
//
// Function
// - primary register: first write kept, later dropped
// - primary register always reads current contents
// - bit 4 stores value, drives nothing
// - bit 7 enables watchdog reset on timeout
// - bit 6 picks long or short timeout
// - bit 5 allows stop, else illegal-opcode reset
// - bit 1 gives shared pin debug function
// - every reset returns pin to debug function
// - bit 0 makes shared pin the reset input
// - bit 0 clears only on power/low-voltage reset
// - pull-up enabled while reset pin selected
// - secondary bit 7 picks watchdog clock source
// - secondary bit 1 picks i2c pin pair
// - secondary bit 0 routes comparator to capture
`timescale 1ns/1ps
`default_nettype none
module sowr_system_options
  import sowr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              por_reset,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              stop_request,
  input  wire logic              analog_comparator_output,
  output logic                   stop_mode_enter,
  output logic                   illegal_opcode_reset,
  output logic                   capture_ch0_from_comparator,
  output logic                   capture_ch0_compare_sel,
  output sowr_opts_s             opts
);

  sowr_wreq_s pri_wreq;
  sowr_wreq_s sec_wreq;
  logic [7:0] pri_q;
  logic       wclk_q;
  logic [1:0] sec_free_q;
  logic [7:0] pri_rdata;
  logic [7:0] sec_rdata;

  sowr_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pri_wreq      (pri_wreq),
    .sec_wreq      (sec_wreq),
    .pri_rdata     (pri_rdata),
    .sec_rdata     (sec_rdata)
  );

  // whole primary register is one write-once group; reset pin bit survives warm resets
  sowr_once_field #(
    .W (8)
  ) u_primary (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .por_reset (por_reset),
    .rst_value (PRI_RST_VALUE),
    .keep_mask (8'h01 << PRI_RST_PIN_BIT),
    .wr_en     (pri_wreq.wr),
    .wr_data   (pri_wreq.data & PRI_WR_MASK),
    .value_q   (pri_q),
    .locked_q  ()
  );

  sowr_once_field #(
    .W (1)
  ) u_wdog_clk (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .por_reset (1'b1),
    .rst_value (SEC_RST_VALUE[SEC_WDOG_CLK_BIT]),
    .keep_mask (1'b0),
    .wr_en     (sec_wreq.wr),
    .wr_data   (sec_wreq.data[SEC_WDOG_CLK_BIT]),
    .value_q   (wclk_q),
    .locked_q  ()
  );

  // i2c location and comparator route rewrite freely
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_free_q <= SEC_RST_VALUE[1:0];
    end else if (sec_wreq.wr) begin
      sec_free_q <= sec_wreq.data[1:0];
    end
  end

  assign pri_rdata = pri_q & PRI_WR_MASK;
  assign sec_rdata = {wclk_q, 5'h00, sec_free_q} & SEC_WR_MASK;

  always_comb begin
    opts.watchdog_enable             = pri_q[PRI_WDOG_EN_BIT];
    opts.watchdog_long_timeout       = pri_q[PRI_WDOG_LONG_BIT];
    opts.stop_mode_allow             = pri_q[PRI_STOP_BIT];
    opts.debug_pin_enable            = pri_q[PRI_DBG_PIN_BIT];
    opts.reset_pin_enable            = pri_q[PRI_RST_PIN_BIT];
    opts.reset_pin_pullup_en         = pri_q[PRI_RST_PIN_BIT];
    opts.watchdog_clock_select       = wclk_q;
    opts.i2c_pin_location_select     = sec_free_q[SEC_I2C_LOC_BIT];
    opts.comparator_to_capture_route = sec_free_q[SEC_CMP_ROUTE_BIT];
  end

  // stop request becomes stop entry or illegal-opcode reset
  assign stop_mode_enter      = stop_request && pri_q[PRI_STOP_BIT];
  assign illegal_opcode_reset = stop_request && !pri_q[PRI_STOP_BIT];

  assign capture_ch0_compare_sel     = sec_free_q[SEC_CMP_ROUTE_BIT];
  assign capture_ch0_from_comparator = sec_free_q[SEC_CMP_ROUTE_BIT] && analog_comparator_output;

endmodule
`default_nettype wire
